// file: design/mmd_memory_map_decoder.sv
// Purpose: System address decoder between the core and memories/registers
// Assumes: Memories and register slaves answer in the cycle after a strobe
// Notes:   One request at a time; core waits for core_ack
//
// Behaviour
// RULE_01: After reset, flash is aliased at address zero.
// RULE_02: Clearing bit 0 of the boot alias register aliases SRAM there.
// RULE_03: Core sees a flat 32-bit byte space, blocks at fixed regions.
// RULE_04: Little-endian: least significant byte at lowest address.
// RULE_05: Flash bank 0 decoded from 0x90000 to 0x9FFFF, top is boot page.
// RULE_06: Flash bank 1 decoded from 0x80000 to 0x8FFFF, all user space.
// RULE_07: 2 kB of flash are boot page, 126 kB code and data.
// RULE_08: Flash pages are 512 bytes.
// RULE_09: 16-bit flash: word fetch takes two accesses, halfword one.
// RULE_10: Flash rate at most 41.78 MHz halfwords, 20.89 MHz words.
// RULE_11: 8 kB SRAM as 32-bit words, one access per word.
// RULE_12: Register space fills the top of the map, all peripheral registers.
// RULE_13: Software never touches unoccupied register locations.
// RULE_14: Single-cycle bus takes one cycle, peripheral bus takes two.
// RULE_15: Interrupt, system control, flash controller and GPIO on single-cycle bus, rest peripheral bus.
// RULE_16: Interrupt controller region at 0xFFFF0000, single cycle.
// RULE_17: System control region at 0xFFFF0200, single cycle.
// RULE_18: Timer region at 0xFFFF0300, two cycles.
// RULE_19: Power/clock at 0xFFFF0400, supply monitor 0xFFFF0440, two cycles.
// RULE_20: Reference, converter, output converter at 0x480/0x500/0x580.
// RULE_21: Unoccupied locations read zero, writes discarded, normal finish.
`timescale 1ns/100ps
`default_nettype none
`include "mmd_consts.svh"

module mmd_memory_map_decoder
    import mmd_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Core request and answer
    input wire logic core_req,
    input wire logic [31:0] core_addr,
    input wire logic core_write,
    input wire logic [1:0] core_size,
    input wire logic [31:0] core_wdata,
    output logic core_ack,
    output logic [31:0] core_rdata,
    // Byte lanes shared by SRAM and register bus
    output logic [3:0] lane_be,
    output logic [31:0] lane_wdata,
    // Flash arrays
    output logic flash_rd,
    output logic flash_bank,
    output logic [14:0] flash_haddr,
    input wire logic [15:0] flash_rdata,
    // SRAM
    output logic sram_en,
    output logic sram_we,
    output logic [10:0] sram_waddr,
    input wire logic [31:0] sram_rdata,
    // Register bus
    output logic [9:0] reg_sel,
    output logic reg_enable,
    output logic reg_write,
    output logic [15:0] reg_addr,
    input wire logic [31:0] reg_rdata,
    // Boot alias state
    output logic alias_flash
);

    localparam logic [15:0] REG_BASE [`MMD_NREG] = '{
        `MMD_IRQ_BASE, `MMD_SYS_BASE, `MMD_FLC_BASE, `MMD_GPIO_BASE,
        `MMD_TMR_BASE, `MMD_PLL_BASE, `MMD_PSM_BASE, `MMD_REF_BASE,
        `MMD_ADC_BASE, `MMD_DAC_BASE};
    localparam logic [15:0] REG_MASK [`MMD_NREG] = '{
        `MMD_IRQ_MASK, `MMD_MASK_256, `MMD_MASK_256, `MMD_MASK_256,
        `MMD_MASK_256, `MMD_MASK_64, `MMD_MASK_64, `MMD_MASK_128,
        `MMD_MASK_128, `MMD_MASK_128};
    localparam logic [15:0] ALIAS_OFS = `MMD_ALIAS_OFS;

    mmd_state_e state_r, state_nxt;
    mmd_tgt_e tgt_r, tgt_nxt;
    logic [7:0] alias_r;
    logic [1:0] lsb_r;
    logic [1:0] size_r;
    logic word_r;
    logic [15:0] lo_r;
    logic ack_r, ack_nxt;
    logic [31:0] rdata_r;
    logic [3:0] be_r;
    logic [31:0] wdata_r;
    logic flash_rd_r, flash_rd_nxt;
    logic flash_bank_r;
    logic [14:0] haddr_r, haddr_nxt;
    logic sram_en_r, sram_en_nxt;
    logic sram_we_r;
    logic [10:0] sram_waddr_r;
    logic [9:0] reg_sel_r, reg_sel_nxt;
    logic reg_en_r, reg_en_nxt;
    logic reg_write_r;
    logic [15:0] reg_addr_r;

    // Region decode on the request address
    wire logic take = (state_r == ST_IDLE) && core_req;
    wire logic in_mmr = core_addr[31:16] == `MMD_MMR_HI; // [RULE_12]
    wire logic [9:0] reg_hit;
    genvar gi;
    generate
        for (gi = 0; gi < `MMD_NREG; gi = gi + 1) begin : g_region
            // Aligned window match per register region
            assign reg_hit[gi] = in_mmr &&
                ((core_addr[15:0] & REG_MASK[gi]) == REG_BASE[gi]); // [RULE_16] [RULE_17] [RULE_18] [RULE_19] [RULE_20]
        end
    endgenerate
    wire logic reg_ahb = |reg_hit[`MMD_NAHB-1:0]; // [RULE_15]
    wire logic reg_apb = |reg_hit[`MMD_NREG-1:`MMD_NAHB]; // [RULE_15]
    wire logic local_hit = in_mmr && (core_addr[15:2] == ALIAS_OFS[15:2]);
    wire logic alias_win = core_addr[31:16] == `MMD_ALIAS_HI;
    wire logic bank1_hit = (core_addr[31:16] == `MMD_BANK1_HI) ||
        (alias_win && alias_r[`MMD_ALIAS_BIT]); // [RULE_01] [RULE_06]
    // Bank 0 holds user pages and the boot page at its top
    wire logic bank0_hit = core_addr[31:16] == `MMD_BANK0_HI; // [RULE_05] [RULE_07]
    wire logic sram_hit = (core_addr[31:13] == `MMD_SRAM_HI) ||
        (alias_win && !alias_r[`MMD_ALIAS_BIT] &&
        core_addr[15:13] == 3'h0); // [RULE_02] [RULE_11]
    // Flash is read-only here, direct writes are dropped
    wire logic flash_hit = (bank0_hit || bank1_hit) && !core_write;

    // Target priority, anything unmatched is unoccupied
    assign tgt_nxt = local_hit ? TGT_LOCAL :
                     reg_ahb ? TGT_AHB :
                     reg_apb ? TGT_APB :
                     flash_hit ? TGT_FLASH :
                     sram_hit ? TGT_SRAM : TGT_NONE; // [RULE_03] [RULE_21]

    // Little-endian byte lanes for writes
    wire logic [3:0] be_nxt = (core_size == `MMD_SZ_BYTE) ?
        (4'h1 << core_addr[1:0]) :
        (core_size == `MMD_SZ_HALF) ? (4'h3 << {core_addr[1], 1'b0}) :
        4'hf; // [RULE_04]
    wire logic [31:0] wlane = core_wdata << {core_addr[1:0], 3'b000}; // [RULE_04]

    // Read data gathered, lowest address to least significant byte
    wire logic [31:0] cap_raw = (tgt_r == TGT_FLASH) ?
        (word_r ? {flash_rdata, lo_r} : {flash_rdata, flash_rdata}) :
        (tgt_r == TGT_SRAM) ? sram_rdata :
        (tgt_r == TGT_AHB || tgt_r == TGT_APB) ? reg_rdata :
        (tgt_r == TGT_LOCAL) ? {24'h000000, alias_r} :
        32'h00000000; // [RULE_04] [RULE_21]
    wire logic [31:0] cap_shift = cap_raw >> {lsb_r, 3'b000};
    wire logic [31:0] cap_val = (size_r == `MMD_SZ_BYTE) ?
        {24'h000000, cap_shift[7:0]} :
        (size_r == `MMD_SZ_HALF) ? {16'h0000, cap_shift[15:0]} :
        cap_shift;

    // Sequencing of each access and its strobes
    always_comb begin
        state_nxt = state_r;
        flash_rd_nxt = 1'b0;
        haddr_nxt = haddr_r;
        sram_en_nxt = 1'b0;
        reg_sel_nxt = 10'h000;
        reg_en_nxt = 1'b0;
        ack_nxt = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (core_req) begin
                    state_nxt = ST_GAP;
                    case (tgt_nxt)
                        TGT_FLASH: begin
                            // Page is bits 15:9, halfword within it 8:1
                            flash_rd_nxt = 1'b1;
                            haddr_nxt = core_addr[15:1]; // [RULE_08]
                            if (core_size == `MMD_SZ_WORD) begin
                                state_nxt = ST_FL_HI; // [RULE_09]
                            end
                        end
                        TGT_SRAM: begin
                            sram_en_nxt = 1'b1; // [RULE_11]
                        end
                        TGT_AHB: begin
                            reg_sel_nxt = reg_hit; // [RULE_14]
                        end
                        TGT_APB: begin
                            reg_sel_nxt = reg_hit;
                            state_nxt = ST_APB_EN; // [RULE_14]
                        end
                        default: begin
                            state_nxt = ST_GAP; // [RULE_21]
                        end
                    endcase
                end
            end
            ST_FL_HI: begin
                // Back-to-back halfwords: one flash access per clock
                flash_rd_nxt = 1'b1;
                haddr_nxt = {haddr_r[14:1], 1'b1}; // [RULE_09] [RULE_10]
                state_nxt = ST_FL_LO;
            end
            ST_FL_LO: begin
                state_nxt = ST_CAPT;
            end
            ST_APB_EN: begin
                reg_sel_nxt = reg_sel_r;
                reg_en_nxt = 1'b1; // [RULE_14]
                state_nxt = ST_GAP;
            end
            ST_GAP: begin
                state_nxt = ST_CAPT;
            end
            ST_CAPT: begin
                ack_nxt = 1'b1;
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // State and strobes
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_r <= ST_IDLE;
            ack_r <= 1'b0;
            flash_rd_r <= 1'b0;
            sram_en_r <= 1'b0;
            reg_sel_r <= 10'h000;
            reg_en_r <= 1'b0;
            haddr_r <= 15'h0000;
        end else begin
            state_r <= state_nxt;
            ack_r <= ack_nxt;
            flash_rd_r <= flash_rd_nxt;
            sram_en_r <= sram_en_nxt;
            reg_sel_r <= reg_sel_nxt;
            reg_en_r <= reg_en_nxt;
            haddr_r <= haddr_nxt;
        end
    end

    // Request fields held for the whole access
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tgt_r <= TGT_NONE;
            lsb_r <= 2'h0;
            size_r <= `MMD_SZ_BYTE;
            word_r <= 1'b0;
            be_r <= 4'h0;
            wdata_r <= 32'h00000000;
            flash_bank_r <= 1'b0;
            sram_we_r <= 1'b0;
            sram_waddr_r <= 11'h000;
            reg_write_r <= 1'b0;
            reg_addr_r <= 16'h0000;
        end else if (take) begin
            tgt_r <= tgt_nxt;
            lsb_r <= core_addr[1:0];
            size_r <= core_size;
            word_r <= core_size == `MMD_SZ_WORD;
            be_r <= be_nxt;
            wdata_r <= wlane;
            flash_bank_r <= bank0_hit; // [RULE_05] [RULE_06]
            sram_we_r <= core_write;
            sram_waddr_r <= core_addr[12:2]; // [RULE_11]
            reg_write_r <= core_write;
            reg_addr_r <= core_addr[15:0];
        end
    end

    // Low flash half of a word, then the answer to the core
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            lo_r <= 16'h0000;
            rdata_r <= 32'h00000000;
        end else begin
            if (state_r == ST_FL_LO) begin
                lo_r <= flash_rdata; // [RULE_09]
            end
            if (state_r == ST_CAPT) begin
                rdata_r <= sram_we_r ? 32'h00000000 : cap_val;
            end
        end
    end

    // Boot alias control, flash aliased after reset
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            alias_r <= `MMD_ALIAS_RST; // [RULE_01]
        end else if (take && core_write && tgt_nxt == TGT_LOCAL &&
                     be_nxt[0]) begin
            alias_r <= wlane[7:0]; // [RULE_02]
        end
    end

    // Outputs, all from flip-flops
    assign core_ack = ack_r;
    assign core_rdata = rdata_r;
    assign lane_be = be_r;
    assign lane_wdata = wdata_r;
    assign flash_rd = flash_rd_r;
    assign flash_bank = flash_bank_r;
    assign flash_haddr = haddr_r;
    assign sram_en = sram_en_r;
    assign sram_we = sram_we_r;
    assign sram_waddr = sram_waddr_r;
    assign reg_sel = reg_sel_r;
    assign reg_enable = reg_en_r;
    assign reg_write = reg_write_r;
    assign reg_addr = reg_addr_r;
    assign alias_flash = alias_r[`MMD_ALIAS_BIT];

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_flash_word;
        take && tgt_nxt == TGT_FLASH && core_size == `MMD_SZ_WORD;
    endsequence
    sequence s_word_beats;
        flash_rd_r && !haddr_r[0] ##1 flash_rd_r && haddr_r[0]
        ##1 !flash_rd_r ##1 ack_r;
    endsequence
    sequence s_apb_phases;
        (|reg_sel_r) && !reg_en_r ##1 (|reg_sel_r) && reg_en_r
        ##1 reg_sel_r == 10'h000 ##1 ack_r;
    endsequence

    chk_alias_flash: assert property ((take && !core_write && alias_win && // [RULE_01]
        alias_r[0]) |=> flash_rd_r && !flash_bank_r)
        else $error("alias read did not reach flash bank 1");
    chk_alias_sram: assert property ((take && !core_write && alias_win && // [RULE_02]
        !alias_r[0] && core_addr[15:13] == 3'h0) |=> sram_en_r)
        else $error("alias read did not reach SRAM");
    chk_alias_write: assert property ((take && core_write && // [RULE_02]
        tgt_nxt == TGT_LOCAL && be_nxt[0]) |=> alias_r[0] == $past(wlane[0]))
        else $error("boot alias bit not written");
    chk_word_fetch: assert property (s_flash_word |=> s_word_beats) // [RULE_09]
        else $error("word flash fetch not two halfword accesses");
    chk_half_fetch: assert property ((take && tgt_nxt == TGT_FLASH && // [RULE_09]
        core_size != `MMD_SZ_WORD) |=> flash_rd_r ##1 !flash_rd_r ##1 ack_r)
        else $error("halfword flash fetch not one access");
    chk_ahb_one: assert property ((take && tgt_nxt == TGT_AHB) |=> // [RULE_14]
        (|reg_sel_r) && !reg_en_r ##1 reg_sel_r == 10'h000 ##1 ack_r)
        else $error("single-cycle register access wrong");
    chk_apb_two: assert property ((take && tgt_nxt == TGT_APB) // [RULE_15]
        |=> s_apb_phases)
        else $error("two-cycle register access wrong");
    chk_unmapped_zero: assert property ((take && tgt_nxt == TGT_NONE) |=> // [RULE_21]
        !flash_rd_r && !sram_en_r && reg_sel_r == 10'h000
        ##1 1'b1 ##1 ack_r && rdata_r == 32'h00000000)
        else $error("unoccupied access not quiet zero");
    chk_sram_lanes: assert property ((take && tgt_nxt == TGT_SRAM && // [RULE_04]
        core_size == `MMD_SZ_BYTE) |=> sram_en_r &&
        be_r == (4'h1 << $past(core_addr[1:0])))
        else $error("SRAM byte lane wrong");
    chk_bank0_sel: assert property ((take && tgt_nxt == TGT_FLASH && // [RULE_05]
        core_addr[31:16] == `MMD_BANK0_HI) |=> flash_bank_r)
        else $error("bank 0 address not routed to bank 0");

endmodule // mmd_memory_map_decoder
`default_nettype wire

// file: design/mmd_consts.svh
// Purpose: Address map, field and reset constants of the memory map decoder
// Assumes: 32-bit byte addresses from the core
// Notes:   Region bases are low address halves inside the register space
`ifndef MMD_CONSTS_SVH
`define MMD_CONSTS_SVH

// Upper address halves of the fixed memory regions
`define MMD_ALIAS_HI 16'h0000
`define MMD_BANK1_HI 16'h0008
`define MMD_BANK0_HI 16'h0009
`define MMD_MMR_HI 16'hffff
// SRAM base 0x00010000, compared on address bits 31:13
`define MMD_SRAM_HI 19'h00008

// Flash layout
`define MMD_BOOT_PAGE_BASE 32'h0009_f800
`define MMD_BOOT_PAGE_BYTES 2048
`define MMD_FLASH_PAGE_BYTES 512
`define MMD_FLASH_PAGE_LSB 9

// Flash rate limits and the system clock, in kHz
`define MMD_SYS_CLK_KHZ 40000
`define MMD_FLASH16_MAX_KHZ 41780
`define MMD_FLASH32_MAX_KHZ 20890

// Register regions: count, single-cycle count, bases and masks
`define MMD_NREG 10
`define MMD_NAHB 4
`define MMD_IRQ_BASE 16'h0000
`define MMD_IRQ_MASK 16'hfe00
`define MMD_SYS_BASE 16'h0200
`define MMD_FLC_BASE 16'hf800
`define MMD_GPIO_BASE 16'h0d00
`define MMD_TMR_BASE 16'h0300
`define MMD_PLL_BASE 16'h0400
`define MMD_PSM_BASE 16'h0440
`define MMD_REF_BASE 16'h0480
`define MMD_ADC_BASE 16'h0500
`define MMD_DAC_BASE 16'h0580
`define MMD_MASK_256 16'hff00
`define MMD_MASK_128 16'hff80
`define MMD_MASK_64 16'hffc0

// Boot alias control register
`define MMD_ALIAS_OFS 16'h0220
`define MMD_ALIAS_RST 8'h01
`define MMD_ALIAS_BIT 0

// Access sizes
`define MMD_SZ_BYTE 2'h0
`define MMD_SZ_HALF 2'h1
`define MMD_SZ_WORD 2'h2

`endif

// file: design/mmd_pkg.sv
// Purpose: Types of the memory map decoder
// Assumes: Nothing beyond the constants header
// Notes:   States and access targets
package mmd_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_FL_HI, ST_FL_LO, ST_APB_EN, ST_GAP, ST_CAPT
    } mmd_state_e;
    typedef enum logic [2:0] {
        TGT_NONE, TGT_FLASH, TGT_SRAM, TGT_AHB, TGT_APB, TGT_LOCAL
    } mmd_tgt_e;
endpackage

// file: tb/mmd_mem_model.sv
// Purpose: Memories and register slaves that answer the decoder
// Assumes: Answers appear in the cycle after the decoder's strobe
// Notes:   Outside an answer every data bus toggles, so stale data shows
`timescale 1ns/100ps
`default_nettype none

module mmd_mem_model (
    // Clock
    input wire logic sys_clk,
    // Lanes
    input wire logic [3:0] lane_be,
    input wire logic [31:0] lane_wdata,
    // Flash
    input wire logic flash_rd,
    input wire logic flash_bank,
    input wire logic [14:0] flash_haddr,
    output logic [15:0] flash_rdata,
    // SRAM
    input wire logic sram_en,
    input wire logic sram_we,
    input wire logic [10:0] sram_waddr,
    output logic [31:0] sram_rdata,
    // Register slaves
    input wire logic [9:0] reg_sel,
    input wire logic [15:0] reg_addr,
    output logic [31:0] reg_rdata
);
    logic [31:0] mem [0:2047];

    // Clear the SRAM so reads of untouched words are known
    initial begin
        for (int i = 0; i < 2048; i++) begin
            mem[i] = 32'h0;
        end
        flash_rdata = 16'h5a5a;
        sram_rdata = 32'h5a5a5a5a;
        reg_rdata = 32'h5a5a5a5a;
    end

    // Halfword flash, word SRAM with byte lanes, register slaves
    always @(posedge sys_clk) begin
        if (flash_rd) begin
            flash_rdata <= {flash_bank, flash_haddr};
        end else begin
            flash_rdata <= ~flash_rdata;
        end
        if (sram_en && sram_we) begin
            for (int i = 0; i < 4; i++) begin
                if (lane_be[i]) begin
                    mem[sram_waddr][8*i+:8] <= lane_wdata[8*i+:8];
                end
            end
        end
        if (sram_en && !sram_we) begin
            sram_rdata <= mem[sram_waddr];
        end else begin
            sram_rdata <= ~sram_rdata;
        end
        if (|reg_sel) begin
            reg_rdata <= {6'h0, reg_sel, reg_addr};
        end else begin
            reg_rdata <= ~reg_rdata;
        end
    end
endmodule // mmd_mem_model

`default_nettype wire

// file: tb/mmd_memory_map_decoder_tb.sv
// Purpose: Self-checking bench of the memory map decoder
// Assumes: Core side driven at the falling edge, one access at a time
// Notes:   Table rows first, then alias switch and mid-run reset
`timescale 1ns/100ps
`default_nettype none
`include "mmd_consts.svh"

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
    mismatches++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
    end end

module mmd_memory_map_decoder_tb;
    typedef struct packed {
        logic [31:0] a;
        logic w;
        logic [1:0] sz;
        logic [31:0] wd;
        logic [31:0] rd;
        logic [3:0] lat;
        logic [9:0] sel;
        logic [1:0] fc;
        logic [1:0] en;
    } mmd_row_s;

    logic sys_clk, reset, core_req, core_write, core_ack, flash_rd, flash_bank;
    logic sram_en, sram_we, reg_enable, reg_write, alias_flash;
    logic [31:0] core_addr, core_wdata, core_rdata, lane_wdata, sram_rdata;
    logic [31:0] reg_rdata, got_rd;
    logic [1:0] core_size, got_fc, got_en;
    logic [3:0] lane_be, got_lat;
    logic [14:0] flash_haddr;
    logic [15:0] flash_rdata, reg_addr;
    logic [10:0] sram_waddr;
    logic [9:0] reg_sel, got_sel;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;

    // Address, write, size, wdata, rdata, latency, select, flash, enable
    // Register rows use occupied locations, except the 0x0600 row
    mmd_row_s rows [0:21] = '{
        '{32'h4, 1'b0, 2'h2, 32'h0, 32'h30002, 4'h4, 10'h0, 2'h2, 2'h0},
        '{32'h8000c, 1'b0, 2'h1, 32'h0, 32'h6, 4'h3, 10'h0, 2'h1, 2'h0},
        '{32'h9f800, 1'b0, 2'h2, 32'h0, 32'hfc01fc00, 4'h4, 10'h0, 2'h2, 2'h0},
        '{32'h90200, 1'b0, 2'h1, 32'h0, 32'h8100, 4'h3, 10'h0, 2'h1, 2'h0},
        '{32'h80000, 1'b1, 2'h2, 32'hdead, 32'h0, 4'h3, 10'h0, 2'h0, 2'h0},
        '{32'h10000, 1'b1, 2'h2, 32'h44332211, 32'h0, 4'h3, 10'h0, 2'h0, 2'h0},
        '{32'h10002, 1'b0, 2'h0, 32'h0, 32'h33, 4'h3, 10'h0, 2'h0, 2'h0},
        '{32'h10002, 1'b0, 2'h1, 32'h0, 32'h4433, 4'h3, 10'h0, 2'h0, 2'h0},
        '{32'h10005, 1'b1, 2'h0, 32'haa, 32'h0, 4'h3, 10'h0, 2'h0, 2'h0},
        '{32'h10004, 1'b0, 2'h2, 32'h0, 32'haa00, 4'h3, 10'h0, 2'h0, 2'h0},
        '{32'hffff0008, 1'b0, 2'h2, 32'h0, 32'h10008, 4'h3, 10'h1, 2'h0, 2'h0},
        '{32'hffff0230, 1'b0, 2'h2, 32'h0, 32'h20230, 4'h3, 10'h2, 2'h0, 2'h0},
        '{32'hfffff800, 1'b0, 2'h2, 32'h0, 32'h4f800, 4'h3, 10'h4, 2'h0, 2'h0},
        '{32'hffff0d04, 1'b0, 2'h2, 32'h0, 32'h80d04, 4'h3, 10'h8, 2'h0, 2'h0},
        '{32'hffff0300, 1'b0, 2'h2, 32'h0, 32'h100300, 4'h4, 10'h10, 2'h0, 2'h1},
        '{32'hffff0404, 1'b0, 2'h2, 32'h0, 32'h200404, 4'h4, 10'h20, 2'h0, 2'h1},
        '{32'hffff0440, 1'b0, 2'h2, 32'h0, 32'h400440, 4'h4, 10'h40, 2'h0, 2'h1},
        '{32'hffff0480, 1'b0, 2'h2, 32'h0, 32'h800480, 4'h4, 10'h80, 2'h0, 2'h1},
        '{32'hffff0500, 1'b0, 2'h2, 32'h0, 32'h1000500, 4'h4, 10'h100, 2'h0, 2'h1},
        '{32'hffff0580, 1'b0, 2'h2, 32'h0, 32'h2000580, 4'h4, 10'h200, 2'h0, 2'h1},
        '{32'hffff0600, 1'b0, 2'h2, 32'h0, 32'h0, 4'h3, 10'h0, 2'h0, 2'h0},
        '{32'h50000, 1'b0, 2'h2, 32'h0, 32'h0, 4'h3, 10'h0, 2'h0, 2'h0}
    };

    mmd_memory_map_decoder DUT (.sys_clk(sys_clk), .reset(reset),
        .core_req(core_req), .core_addr(core_addr), .core_write(core_write),
        .core_size(core_size), .core_wdata(core_wdata), .core_ack(core_ack),
        .core_rdata(core_rdata), .lane_be(lane_be), .lane_wdata(lane_wdata),
        .flash_rd(flash_rd), .flash_bank(flash_bank),
        .flash_haddr(flash_haddr), .flash_rdata(flash_rdata),
        .sram_en(sram_en), .sram_we(sram_we), .sram_waddr(sram_waddr),
        .sram_rdata(sram_rdata), .reg_sel(reg_sel), .reg_enable(reg_enable),
        .reg_write(reg_write), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
        .alias_flash(alias_flash));

    mmd_mem_model partner (.sys_clk(sys_clk), .lane_be(lane_be),
        .lane_wdata(lane_wdata), .flash_rd(flash_rd),
        .flash_bank(flash_bank), .flash_haddr(flash_haddr),
        .flash_rdata(flash_rdata), .sram_en(sram_en), .sram_we(sram_we),
        .sram_waddr(sram_waddr), .sram_rdata(sram_rdata), .reg_sel(reg_sel),
        .reg_addr(reg_addr), .reg_rdata(reg_rdata));

    // 40 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Print counts and verdict, then stop
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One access from a falling edge; counts strobes until the ack
    task automatic access(input logic [31:0] a, input logic w,
        input logic [1:0] sz, input logic [31:0] wd);
        int n;
        core_addr = a;
        core_write = w;
        core_size = sz;
        core_wdata = wd;
        core_req = 1'b1;
        got_sel = 10'h0;
        got_fc = 2'h0;
        got_en = 2'h0;
        @(negedge sys_clk);
        core_req = 1'b0;
        n = 1;
        while (core_ack !== 1'b1 && n < 8) begin
            got_sel = got_sel | reg_sel;
            got_fc = got_fc + 2'(flash_rd);
            got_en = got_en + 2'(reg_enable);
            n++;
            @(negedge sys_clk);
        end
        got_lat = 4'(n);
        got_rd = core_rdata;
    endtask

    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            give_verdict();
        end
    end

    // Main sequence
    initial begin
        reset = 1'b1;
        core_req = 1'b0;
        core_addr = 32'h0;
        core_write = 1'b0;
        core_size = 2'h0;
        core_wdata = 32'h0;
        repeat (20) @(negedge sys_clk);
        `CHK(core_ack, 1'b0)
        `CHK(alias_flash, 1'b1)
        $display("reset values done");
        reset = 1'b0;
        @(negedge sys_clk);
        foreach (rows[i]) begin
            access(rows[i].a, rows[i].w, rows[i].sz, rows[i].wd);
            `CHK(got_rd, rows[i].rd)
            `CHK(got_lat, rows[i].lat)
            `CHK(got_sel, rows[i].sel)
            `CHK(got_fc, rows[i].fc)
            `CHK(got_en, rows[i].en)
            `CHK(reg_write, rows[i].w)
            `CHK(sram_we, rows[i].w)
            `CHK(reg_addr, rows[i].a[15:0])
            $display("row %0d done", i);
        end
        // Register write on the single-cycle bus, little-endian lanes
        access(32'hffff0d0a, 1'b1, `MMD_SZ_HALF, 32'h5678);
        `CHK(got_sel, 10'h8)
        `CHK(lane_be, 4'hc)
        `CHK(lane_wdata, 32'h56780000)
        `CHK(reg_write, 1'b1)
        `CHK(got_rd, 32'h0)
        $display("register write done");
        // Boot alias: reset value, then SRAM at address zero
        access(32'hffff0220, 1'b0, `MMD_SZ_BYTE, 32'h0);
        `CHK(got_rd, 32'h1)
        `CHK(got_sel, 10'h0)
        access(32'hffff0220, 1'b1, `MMD_SZ_BYTE, 32'h0);
        `CHK(alias_flash, 1'b0)
        access(32'h0, 1'b0, `MMD_SZ_WORD, 32'h0);
        `CHK(got_rd, 32'h44332211)
        `CHK(got_fc, 2'h0)
        // Above the first 8 kB the SRAM alias window is unoccupied
        access(32'h4000, 1'b0, `MMD_SZ_WORD, 32'h0);
        `CHK(got_rd, 32'h0)
        `CHK(got_fc, 2'h0)
        $display("alias switch done");
        // Reset in mid-access brings flash back at zero
        access(32'h0, 1'b0, `MMD_SZ_WORD, 32'h0);
        core_addr = 32'h80000;
        core_size = `MMD_SZ_WORD;
        core_req = 1'b1;
        @(negedge sys_clk);
        core_req = 1'b0;
        reset = 1'b1;
        @(negedge sys_clk);
        `CHK(alias_flash, 1'b1)
        `CHK(flash_rd, 1'b0)
        reset = 1'b0;
        @(negedge sys_clk);
        access(32'h0, 1'b0, `MMD_SZ_WORD, 32'h0);
        `CHK(got_rd, 32'h10000)
        $display("mid-run reset done");
        give_verdict();
    end
endmodule // mmd_memory_map_decoder_tb

`undef CHK
`default_nettype wire
